/* rtl/rss_defines.vh */
// register offsets, field positions, reset values and timing counts for the reset sequencer
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
`define RSS_ADDR_SUPPLY_MON   8'h13
`define RSS_ADDR_RESET_CAUSE  8'h73
`define RSS_ADDR_SOFT_RESET   8'h75
`define RSS_ADDR_RESET_ENABLE 8'h76
`define RSS_BIT_MON_EN        7
`define RSS_BIT_MON_STAT      6
`define RSS_BIT_SOFT_RESET    2
`define RSS_BIT_CAUSE_SOFT    2
`define RSS_BIT_CAUSE_POWER   1
`define RSS_BIT_CAUSE_PIN     0
`define RSS_BIT_EN_SOFT       2
`define RSS_BIT_EN_SUPPLY     1
`define RSS_RESET_ENABLE_RST  8'h04
`define RSS_REG_RST           8'h00
`define RSS_CLK_MHZ           250
`define RSS_POR_DELAY_US      5000
`define RSS_OSC_FAIL_US       1000
`define RSS_PIN_EXIT_NS       4000
`define RSS_OSC_SETTLE_US     1000
`define RSS_POR_CYCLES        (`RSS_POR_DELAY_US * `RSS_CLK_MHZ)
`define RSS_OSC_FAIL_CYCLES   (`RSS_OSC_FAIL_US * `RSS_CLK_MHZ)
`define RSS_PIN_EXIT_CYCLES   (`RSS_PIN_EXIT_NS * `RSS_CLK_MHZ / 1000)
`define RSS_OSC_SETTLE_CYCLES (`RSS_OSC_SETTLE_US * `RSS_CLK_MHZ)
`define RSS_ST_RESET          3'h0
`define RSS_ST_HOLD           3'h1
`define RSS_ST_OSC_WAIT       3'h2
`define RSS_ST_CALIB          3'h3
`define RSS_ST_RUN            3'h4
`endif

/* rtl/rss_reset_sequencer.v */
// reset source sequencer: merges reset sources, sequences exit, records cause
// Functional notes
// [R1] reset entry loads all registers with their reset values; code reloads only the soft enable on reset entry
// [R2] in reset, digital pins except reset pin released, weak pull-up on
// [R3] non-software reset entry stops oscillator and drives reset pin low; code leaves the pin undriven when a pin request is active at entry
// [R4] all interrupt enables come up enabled after reset
// [R5] buffer contents kept, buffer pointers return to default on reset
// [R6] five reset sources; entering source sets time in reset and pin behaviour
// [R7] on exit start oscillator, wait settle, raise init-complete interrupt; not soft
// [R8] host without interrupt waits about 1 ms after pin rise before polling
// [R9] host tolerates reset pin low up to 100 ms after power-up
// [R10] self-init completion flag readable; device functional only after it
// [R11] power-up holds reset until supply good, then 5 ms release delay
// [R12] supply fail drives pin low and resets; release when supply good again
// [R13] after power-on, supply monitor enabled and selected as reset source
// [R14] bit 7 of supply monitor control enables monitor; software waits stabilise
// [R15] bit 6 of supply monitor control reads live monitor output
// [R16] clock fail after osc init: pin low, 1 ms reset, exit like power-on
// [R17] external pin low forces reset; exit about 4 us after high seen
// [R18] soft reset bit 2 write resets without stopping oscillator, calibrates, no interrupt
// [R19] software reset source enabled after every reset, can be deselected
// [R20] cause register: bit 2 soft, bit 1 power/osc, bit 0 pin
// [R21] power-on, supply-fail, clock-fail share one cause indicator
// [R22] reset enable bit 2 selects soft, bit 1 selects supply monitor
// [R23] enabled requests merge into one sync reset; cause captured at entry
//
// design notes
// - pins, oscillator status and supply monitor are async: two flops before use
// - the reset pin is open drain: the device only ever pulls it low
// - after the device lets go of the pin, the synchronised level lags by two
//   clocks; a pin request is armed only once the pin has been seen high again,
//   otherwise the device's own release would look like an external reset
// - power-on, supply fail and clock fail share one cause bit and one exit path
// - a pin reset waits for the pin to go high, then a fixed exit count
// - a soft reset skips the hold and oscillator steps and goes to calibration
// - the init interrupt is set on oscillator settle, cleared by a cause read;
//   if both fall in one cycle the set wins
// - supply selection survives non-power resets; soft selection is re-armed
// - counters restart whenever the condition for release is lost
// - the reset enable register is not among the host-visible documented set
//   and sits at a free offset
//
`timescale 1ns/1ps
`include "rss_defines.vh"
module rss_reset_sequencer #(
    parameter POR_CYCLES        = `RSS_POR_CYCLES,
    parameter OSC_FAIL_CYCLES   = `RSS_OSC_FAIL_CYCLES,
    parameter OSC_SETTLE_CYCLES = `RSS_OSC_SETTLE_CYCLES
) (
    input  wire       clock_in,
    input  wire       arst_n_in,
    input  wire       supply_above_threshold_in,
    input  wire       osc_clock_ok_in,
    input  wire       reset_pin_n_in,
    input  wire       calib_done_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    output reg  [7:0] reg_rdata_out,
    output wire       reset_pin_n_oe_out,
    output wire       reset_pin_n_out,
    output wire       pins_release_out,
    output wire       pin_pullup_out,
    output wire       osc_enable_out,
    output wire       device_reset_out,
    output wire       buffer_ptr_reset_out,
    output wire       calib_start_out,
    output wire       osc_init_irq_out,
    output wire       self_init_done_out,
    output wire       int_enable_all_out,
    output wire       supply_monitor_enable_out,
    output wire       device_ready_out
);
    localparam [31:0] PIN_EXIT_CYCLES = `RSS_PIN_EXIT_CYCLES;
    localparam [2:0]  ST_RESET    = `RSS_ST_RESET;
    localparam [2:0]  ST_HOLD     = `RSS_ST_HOLD;
    localparam [2:0]  ST_OSC_WAIT = `RSS_ST_OSC_WAIT;
    localparam [2:0]  ST_CALIB    = `RSS_ST_CALIB;
    localparam [2:0]  ST_RUN      = `RSS_ST_RUN;

    // two-flop synchronisers for pins and analog monitor outputs
    reg  [2:0] sync1_q;
    reg  [2:0] sync2_q;
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {osc_clock_ok_in, reset_pin_n_in, supply_above_threshold_in};
            sync2_q <= sync1_q;
        end
    end
    wire supply_ok = sync2_q[0];
    wire pin_high  = sync2_q[1];
    wire clk_ok    = sync2_q[2];

    reg  [2:0]  state_q;
    reg  [31:0] cnt_q;
    reg  [2:0]  cause_q;
    reg         mon_en_q;
    reg         en_soft_q;
    reg         en_supply_q;
    reg         osc_init_done_q;
    reg         osc_irq_q;
    reg         self_done_q;
    reg         soft_entry_q;
    reg         pin_drive_q;
    reg         por_pending_q;
    reg         pin_armed_q;

    // [R17] pin request armed only after pin seen high while not driven
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_armed_q <= 1'b0;
        end else if (pin_drive_q) begin
            // own drive: ignore pin until released and seen high
            pin_armed_q <= 1'b0;
        end else if (pin_high) begin
            pin_armed_q <= 1'b1;
        end
    end

    // request decode
    wire soft_wr   = reg_wr_in && (reg_addr_in == `RSS_ADDR_SOFT_RESET) && reg_wdata_in[`RSS_BIT_SOFT_RESET];
    // [R22] source selection gates
    wire soft_req  = soft_wr && en_soft_q;
    wire supply_req = en_supply_q && mon_en_q && !supply_ok;
    // [R16] clock loss only after osc init
    wire osc_req   = osc_init_done_q && !clk_ok;
    // [R17] external pin request
    wire pin_req   = !pin_high && !pin_drive_q && pin_armed_q;
    wire in_reset  = (state_q == ST_RESET) || (state_q == ST_HOLD);
    // [R23] merged synchronous reset request
    wire any_req   = !in_reset && (soft_req || supply_req || osc_req || pin_req);

    // main reset sequence
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q         <= ST_RESET;
            cnt_q           <= 32'h0;
            cause_q         <= 3'h2;
            osc_init_done_q <= 1'b0;
            osc_irq_q       <= 1'b0;
            self_done_q     <= 1'b0;
            soft_entry_q    <= 1'b0;
            pin_drive_q     <= 1'b1;
            por_pending_q   <= 1'b1;
        end else begin
            case (state_q)
                ST_RESET: begin
                    // [R11] wait for supply before release delay
                    if (soft_entry_q) begin
                        state_q <= ST_CALIB;
                    end else if (supply_ok) begin
                        state_q <= ST_HOLD;
                        cnt_q   <= 32'h0;
                    end
                end
                ST_HOLD: begin
                    // [R6] source-dependent time in reset
                    cnt_q <= cnt_q + 32'h1;
                    if (cause_q[`RSS_BIT_CAUSE_PIN]) begin
                        pin_drive_q <= 1'b0;
                        if (!pin_high) begin
                            cnt_q <= 32'h0;
                        end else if (cnt_q + 32'h1 >= PIN_EXIT_CYCLES) begin
                            state_q <= ST_OSC_WAIT;
                            cnt_q   <= 32'h0;
                        end
                    end else if (!supply_ok) begin
                        // [R12] release only when supply good again
                        cnt_q <= 32'h0;
                    end else if (cnt_q + 32'h1 >= (por_pending_q ? POR_CYCLES : OSC_FAIL_CYCLES)) begin
                        state_q       <= ST_OSC_WAIT;
                        cnt_q         <= 32'h0;
                        pin_drive_q   <= 1'b0;
                        por_pending_q <= 1'b0;
                    end
                end
                ST_OSC_WAIT: begin
                    // [R7] oscillator settle then init interrupt
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q + 32'h1 >= OSC_SETTLE_CYCLES) begin
                        state_q         <= ST_CALIB;
                        osc_init_done_q <= 1'b1;
                        osc_irq_q       <= 1'b1;
                    end
                end
                ST_CALIB: begin
                    soft_entry_q <= 1'b0;
                    // [R10] self-init completion flag
                    if (calib_done_in) begin
                        state_q     <= ST_RUN;
                        self_done_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
            // init interrupt flag cleared by reading the cause register
            if (reg_rd_in && (reg_addr_in == `RSS_ADDR_RESET_CAUSE) && (state_q != ST_OSC_WAIT)) begin
                osc_irq_q <= 1'b0;
            end
            if (any_req) begin
                state_q     <= ST_RESET;
                cnt_q       <= 32'h0;
                self_done_q <= 1'b0;
                osc_irq_q   <= 1'b0;
                // [R18] soft reset keeps oscillator and pin
                if (soft_req && !(supply_req || osc_req || pin_req)) begin
                    soft_entry_q <= 1'b1;
                    cause_q      <= 3'h4;
                end else begin
                    // [R3] stop oscillator, drive pin low unless entry came from the pin request
                    soft_entry_q    <= 1'b0;
                    osc_init_done_q <= 1'b0;
                    pin_drive_q     <= !pin_req;
                    // [R21] shared power/oscillator indicator
                    cause_q         <= pin_req && !(supply_req || osc_req) ? 3'h1 : 3'h2;
                end
            end
        end
    end

    // software registers; only the soft enable is reinitialised on reset entry
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // [R13] monitor on and selected after power-on
            mon_en_q    <= 1'b1;
            en_supply_q <= 1'b1;
            en_soft_q   <= 1'b1;
        end else if (any_req) begin
            // [R19] soft source re-enabled; monitor and supply enables not reset
            en_soft_q   <= 1'b1;
            // supply monitor state kept across non-power resets
            mon_en_q    <= mon_en_q;
        end else if (reg_wr_in) begin
            // [R14] monitor enable bit
            if (reg_addr_in == `RSS_ADDR_SUPPLY_MON) begin
                mon_en_q <= reg_wdata_in[`RSS_BIT_MON_EN];
            end else if (reg_addr_in == `RSS_ADDR_RESET_ENABLE) begin
                en_soft_q   <= reg_wdata_in[`RSS_BIT_EN_SOFT];
                en_supply_q <= reg_wdata_in[`RSS_BIT_EN_SUPPLY];
            end
        end
    end

    // register read mux
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= `RSS_REG_RST;
        end else if (reg_addr_in == `RSS_ADDR_SUPPLY_MON) begin
            // [R15] live monitor status
            reg_rdata_out <= {mon_en_q, supply_ok, 6'h00};
        end else if (reg_addr_in == `RSS_ADDR_RESET_CAUSE) begin
            // [R20] cause bits
            reg_rdata_out <= {5'h00, cause_q};
        end else if (reg_addr_in == `RSS_ADDR_RESET_ENABLE) begin
            reg_rdata_out <= {5'h00, en_soft_q, en_supply_q, 1'b0};
        end else begin
            reg_rdata_out <= `RSS_REG_RST;
        end
    end

    // [R2] pins released with pull-up in reset, soft entry included
    assign pins_release_out          = in_reset || soft_entry_q;
    assign pin_pullup_out            = in_reset || soft_entry_q;

    // [R3] reset pin open-drain drive
    assign reset_pin_n_out           = 1'b0;
    assign reset_pin_n_oe_out        = pin_drive_q;

    // oscillator kept running through a soft entry
    assign osc_enable_out            = !in_reset || soft_entry_q;

    // device reset covers the soft entry cycle too
    assign device_reset_out          = in_reset || soft_entry_q;

    // [R5] pointers reset, buffer memory untouched
    assign buffer_ptr_reset_out      = in_reset || soft_entry_q;

    // calibration request and status
    assign calib_start_out           = (state_q == ST_CALIB);
    assign osc_init_irq_out          = osc_irq_q;
    assign self_init_done_out        = self_done_q;

    // [R4] interrupt enables forced on in reset
    assign int_enable_all_out        = device_reset_out;

    // monitor enable and run status
    assign supply_monitor_enable_out = mon_en_q;
    assign device_ready_out          = (state_q == ST_RUN);
endmodule // rss_reset_sequencer

/* bench/rss_far_model.sv */
// far side model: reset pin wire, oscillator and calibration responders
`timescale 1ns/1ps
module rss_far_model (
    input  wire clock_in,
    input  wire dev_pull_in,
    input  wire host_pull_in,
    input  wire osc_en_in,
    input  wire osc_kill_in,
    input  wire calib_start_in,
    output wire pin_n_out,
    output reg  osc_ok_out = 1'b0,
    output reg  calib_done_out = 1'b0
);
    assign pin_n_out = ~(dev_pull_in | host_pull_in); // pull-up when nobody drives
    // oscillator and calibration answer one cycle late
    always @(posedge clock_in) begin
        osc_ok_out     <= osc_en_in & ~osc_kill_in;
        calib_done_out <= calib_start_in;
    end
endmodule // rss_far_model

/* bench/rss_reset_sequencer_sva.sv */
// port assertions for the reset source sequencer
`timescale 1ns/1ps
module rss_reset_sequencer_sva (
    input wire       clock_in, arst_n_in, osc_clock_ok_in, reg_wr_in, reg_rd_in,
    input wire [7:0] reg_addr_in, reg_wdata_in,
    input wire       reset_pin_n_oe_out, pins_release_out, pin_pullup_out, osc_enable_out,
    input wire       device_reset_out, buffer_ptr_reset_out, osc_init_irq_out,
    input wire       self_init_done_out, int_enable_all_out, device_ready_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    // soft reset write in run state, cause read with init interrupt pending
    sequence soft_wr_s; device_ready_out && reg_wr_in && reg_addr_in == 8'h75 && reg_wdata_in[2]; endsequence
    sequence cause_rd_s; osc_init_irq_out && reg_rd_in && reg_addr_in == 8'h73; endsequence
    sequence clk_lost_s; device_ready_out && !osc_clock_ok_in [*3]; endsequence
    a_pins_float: assert property (device_reset_out |-> pins_release_out && pin_pullup_out)
        else $error("pins not released in reset");
    a_pin_drive_reset: assert property (reset_pin_n_oe_out |-> !device_ready_out)
        else $error("pin pulled low outside reset");
    a_int_enables: assert property (device_reset_out |-> int_enable_all_out)
        else $error("interrupt enables not set in reset");
    a_ptr_reset: assert property (device_reset_out |-> buffer_ptr_reset_out)
        else $error("buffer pointers not reset");
    a_irq_read_clear: assert property (cause_rd_s |=> !osc_init_irq_out)
        else $error("init interrupt not cleared by read");
    a_ready_init_done: assert property ($rose(device_ready_out) |-> ##[0:2] self_init_done_out)
        else $error("ready without init done");
    a_ready_not_reset: assert property (device_ready_out |-> !device_reset_out)
        else $error("ready while in reset");
    a_clk_fail_entry: assert property (clk_lost_s |-> ##[0:4] reset_pin_n_oe_out)
        else $error("clock loss did not pull pin");
    a_soft_keeps_osc: assert property (soft_wr_s |=> (osc_enable_out && !reset_pin_n_oe_out && !osc_init_irq_out) [*4])
        else $error("soft reset touched oscillator or pin");
endmodule // rss_reset_sequencer_sva
bind rss_reset_sequencer rss_reset_sequencer_sva rss_reset_sequencer_sva_i (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .osc_clock_ok_in(osc_clock_ok_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reset_pin_n_oe_out(reset_pin_n_oe_out), .pins_release_out(pins_release_out), .pin_pullup_out(pin_pullup_out),
    .osc_enable_out(osc_enable_out), .device_reset_out(device_reset_out), .buffer_ptr_reset_out(buffer_ptr_reset_out),
    .osc_init_irq_out(osc_init_irq_out), .self_init_done_out(self_init_done_out),
    .int_enable_all_out(int_enable_all_out), .device_ready_out(device_ready_out));

/* bench/test_rss_reset_sequencer.sv */
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
module test_rss_reset_sequencer;
    reg        clock_in = 1'b0, arst_n_in = 1'b0, supply = 1'b0, host_pull = 1'b0, osc_kill = 1'b0;
    reg        wr = 1'b0, rd = 1'b0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00, v;
    wire [7:0] rdata;
    wire       pin_n, osc_ok, calib_done, oe, osc_en, dev_rst, calib_start, irq, ready;
    int        n_mismatch = 0, samples_checked = 0;
    int        cause_q[$] = '{2, 2, 1, 4, 2}; // expected cause per reset, in test order
    // clock
    always #2 clock_in = ~clock_in;
    rss_reset_sequencer #(.POR_CYCLES(20), .OSC_FAIL_CYCLES(20), .OSC_SETTLE_CYCLES(20)) rss_reset_sequencer_i (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .supply_above_threshold_in(supply),
        .osc_clock_ok_in(osc_ok), .reset_pin_n_in(pin_n), .calib_done_in(calib_done), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reset_pin_n_oe_out(oe), .reset_pin_n_out(), .pins_release_out(), .pin_pullup_out(),
        .osc_enable_out(osc_en), .device_reset_out(dev_rst), .buffer_ptr_reset_out(),
        .calib_start_out(calib_start), .osc_init_irq_out(irq), .self_init_done_out(),
        .int_enable_all_out(), .supply_monitor_enable_out(), .device_ready_out(ready));
    rss_far_model rss_far_model_i (
        .clock_in(clock_in), .dev_pull_in(oe), .host_pull_in(host_pull), .osc_en_in(osc_en),
        .osc_kill_in(osc_kill), .calib_start_in(calib_start), .pin_n_out(pin_n), .osc_ok_out(osc_ok),
        .calib_done_out(calib_done));
    // compare one value
    task check(input [7:0] got, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // register bus cycles
    task wr_reg(input [7:0] a, input [7:0] d);
        @(posedge clock_in);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask
    task rd_reg(input [7:0] a, output [7:0] d);
        @(posedge clock_in);
        rd <= 1'b1; addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // host waits on ready, bounded far beyond the long pin exit count
    // wait for run state, then check interrupt and cause
    task settle_and_cause(input [7:0] exp_irq);
        int i;
        for (i = 0; i < 3000 && ready !== 1'b1; i++) @(posedge clock_in);
        #1 check({7'h0, ready}, 8'h01);
        check({7'h0, irq}, exp_irq);
        rd_reg(8'h73, v);
        check(v, 8'(cause_q.pop_front()));
        check({7'h0, irq}, 8'h00);
    endtask
    task tally_and_finish;
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        void'($urandom(52));
        repeat (10) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat ($urandom_range(30, 5)) @(posedge clock_in);
        #1 check({7'h0, oe}, 8'h01);
        supply <= 1'b1;
        settle_and_cause(8'h01);
        rd_reg(8'h13, v);
        check(v & 8'hc0, 8'hc0);
        rd_reg(8'h76, v);
        check(v & 8'h06, 8'h06);
        supply <= 1'b0;
        repeat (6) @(posedge clock_in);
        #1 check({7'h0, oe}, 8'h01);
        supply <= 1'b1;
        settle_and_cause(8'h01);
        host_pull <= 1'b1;
        repeat (20) @(posedge clock_in);
        host_pull <= 1'b0;
        repeat (990) @(posedge clock_in);
        #1 check({7'h0, dev_rst}, 8'h01);
        settle_and_cause(8'h01);
        wr_reg(8'h75, 8'($urandom) | 8'h04);
        #1 check({7'h0, oe}, 8'h00);
        settle_and_cause(8'h00);
        wr_reg(8'h76, 8'h00);
        wr_reg(8'h75, 8'h04);
        supply <= 1'b0;
        repeat (20) @(posedge clock_in);
        #1 check({7'h0, ready}, 8'h01);
        rd_reg(8'h73, v);
        check(v, 8'h04);
        rd_reg(8'h13, v);
        check(v & 8'h40, 8'h00);
        supply <= 1'b1;
        osc_kill <= 1'b1;
        repeat (6) @(posedge clock_in);
        #1 check({7'h0, oe}, 8'h01);
        osc_kill <= 1'b0;
        settle_and_cause(8'h01);
        rd_reg(8'h76, v);
        check(v & 8'h04, 8'h04);
        tally_and_finish;
    end
    // watchdog
    initial begin
        #(40000 * 4);
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
endmodule // test_rss_reset_sequencer
